// ---- logic/stu_map.vh ----
// Register map, field positions, reset values and encodings of the trigger unit.
// Assumes inclusion by bare name from logic/ and tb/ files.
`ifndef STU_MAP_VH
`define STU_MAP_VH
// Register byte offsets
`define STU_CTRL_OFF 12'h000
`define STU_STAT_OFF 12'h004
`define STU_PRE_OFF 12'h008
`define STU_C0_CFG_OFF 12'h010
`define STU_C0_CMP_OFF 12'h014
`define STU_C0_MIN_OFF 12'h018
`define STU_C1_CFG_OFF 12'h020
`define STU_C1_CMP_OFF 12'h024
`define STU_C1_MIN_OFF 12'h028
`define STU_SRC0_OFF 12'h030
`define STU_SRC1_OFF 12'h034
// Control fields
`define STU_CTRL_MODE_LSB 0
`define STU_CTRL_OP_LSB 4
`define STU_CTRL_START_BIT 8
`define STU_CTRL_STOP_BIT 9
`define STU_CTRL_RST 32'h00000000
// Condition config fields
`define STU_CFG_SRC_LSB 0
`define STU_CFG_TYPE_LSB 2
`define STU_CFG_REL_LSB 4
`define STU_CFG_ABS_BIT 8
`define STU_CFG_MASK_BIT 9
`define STU_CFG_EDGE_BIT 10
`define STU_CFG_SEL_LSB 16
`define STU_CFG_RST 32'h00000000
// Trigger modes
`define STU_MODE_STOP 2'h0
`define STU_MODE_START 2'h1
`define STU_MODE_SIMPLE 2'h2
`define STU_MODE_LOGIC 2'h3
// Sources
`define STU_SRC_INACTIVE 2'h0
`define STU_SRC_PARAM 2'h1
`define STU_SRC_SIGNAL 2'h2
`define STU_SRC_ADDR 2'h3
// Data types for an address source
`define STU_TYPE_S32 2'h0
`define STU_TYPE_U32 2'h1
`define STU_TYPE_S16 2'h2
`define STU_TYPE_U16 2'h3
// Relational tests
`define STU_REL_LT 3'h0
`define STU_REL_LE 3'h1
`define STU_REL_GT 3'h2
`define STU_REL_GE 3'h3
`define STU_REL_EQ 3'h4
`define STU_REL_NE 3'h5
// Operators
`define STU_OP_AND 3'h0
`define STU_OP_OR 3'h1
`define STU_OP_XOR 3'h2
`define STU_OP_NAND 3'h3
`define STU_OP_NOR 3'h4
`define STU_OP_XNOR 3'h5
`define STU_OP_FIRST 3'h6
`define STU_OP_SECOND 3'h7
// Timing: clocks in one microsecond at 125 MHz; sized so hold products keep width
`define STU_CYC_PER_US 8'h7d
`define STU_PRE_MAX 8'h64
`endif

// ---- logic/stu_pretrig.v ----
// Pre-trigger fill tracker: counts samples written since start.
// Assumes capture depth in samples and one sample strobe per stored sample.
`timescale 1ns/1ps
`default_nettype none
module stu_pretrig #(
   parameter DEPTH_W = 16
) (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // Control
   input wire start,
   input wire sample_stb,
   input wire [7:0] pre_pct,
   input wire [DEPTH_W-1:0] depth,
   // Status
   output reg ready_reg
);
   reg [DEPTH_W-1:0] fill_reg;
   wire [DEPTH_W+7:0] need;
   wire [DEPTH_W+7:0] have;

   // Percentage compare without a divider: fill*100 >= depth*pct
   assign need = depth * pre_pct;
   assign have = fill_reg * 8'h64;

   // Fill counter restarts on each start; saturates at full depth
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fill_reg <= {DEPTH_W{1'b0}};
         ready_reg <= 1'b0;
      end else if (start) begin
         fill_reg <= {DEPTH_W{1'b0}};
         ready_reg <= 1'b0;
      end else begin
         if (sample_stb && fill_reg != depth)
            fill_reg <= fill_reg + 1'b1;
         ready_reg <= (have >= need);
      end
   end
endmodule // stu_pretrig
`default_nettype wire

// ---- logic/stu_cond.v ----
// One trigger condition: source select, abs, mask, relation, hold, edge.
// Assumes the sample strobe marks the samples the condition is tested on.
`timescale 1ns/1ps
`default_nettype none
`include "stu_map.vh"
module stu_cond #(
   parameter MIN_W = 16
) (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // Sample inputs
   input wire sample_stb,
   input wire [31:0] param_val,
   input wire [31:0] signal_val,
   input wire [31:0] addr_val,
   // Configuration
   input wire [31:0] cfg,
   input wire [31:0] cmp_val,
   input wire [MIN_W-1:0] min_us,
   input wire arm,
   // Result
   output reg met_reg
);
   wire [1:0] src = cfg[`STU_CFG_SRC_LSB+1:`STU_CFG_SRC_LSB];
   wire [1:0] dtype = cfg[`STU_CFG_TYPE_LSB+1:`STU_CFG_TYPE_LSB];
   wire [2:0] rel = cfg[`STU_CFG_REL_LSB+2:`STU_CFG_REL_LSB];
   wire abs_en = cfg[`STU_CFG_ABS_BIT];
   wire mask_en = cfg[`STU_CFG_MASK_BIT];
   wire edge_en = cfg[`STU_CFG_EDGE_BIT];
   wire [4:0] bit_sel = cfg[`STU_CFG_SEL_LSB+4:`STU_CFG_SEL_LSB];
   reg [31:0] raw;
   reg [32:0] lhs;
   reg [32:0] rhs;
   reg rel_true;
   reg [MIN_W+7:0] hold_reg;
   reg held_prev_reg;
   wire [MIN_W+7:0] hold_need;
   wire held;

   // Source choice; address source interpreted per data type
   always @* begin
      raw = 32'h00000000;
      if (src == `STU_SRC_PARAM)
         raw = param_val;
      else if (src == `STU_SRC_SIGNAL)
         raw = signal_val;
      else if (src == `STU_SRC_ADDR) begin
         case (dtype)
            `STU_TYPE_S16: raw = {{16{addr_val[15]}}, addr_val[15:0]};
            `STU_TYPE_U16: raw = {16'h0000, addr_val[15:0]};
            default: raw = addr_val;
         endcase
      end
   end

   // Operands made 33-bit signed; abs drops signs of both sides
   always @* begin
      lhs = {raw[31], raw};
      if (src == `STU_SRC_ADDR && (dtype == `STU_TYPE_U32 || dtype == `STU_TYPE_U16))
         lhs = {1'b0, raw};
      rhs = {cmp_val[31], cmp_val};
      if (abs_en) begin
         if (lhs[32]) lhs = ~lhs + 33'h1;
         if (rhs[32]) rhs = ~rhs + 33'h1;
      end
      if (mask_en) begin
         lhs = {32'h00000000, raw[bit_sel]};
         rhs = {32'h00000000, cmp_val[0]};
      end
   end

   // Relational test, source on the left
   always @* begin
      case (rel)
         `STU_REL_LT: rel_true = $signed(lhs) < $signed(rhs);
         `STU_REL_LE: rel_true = $signed(lhs) <= $signed(rhs);
         `STU_REL_GT: rel_true = $signed(lhs) > $signed(rhs);
         `STU_REL_GE: rel_true = $signed(lhs) >= $signed(rhs);
         `STU_REL_EQ: rel_true = lhs == rhs;
         `STU_REL_NE: rel_true = lhs != rhs;
         default: rel_true = 1'b0;
      endcase
      if (src == `STU_SRC_INACTIVE)
         rel_true = 1'b0;
   end

   assign hold_need = min_us * `STU_CYC_PER_US;
   assign held = rel_true && (hold_reg >= hold_need);

   // Hold timer counts clocks of continuous truth; saturates
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_reg <= {(MIN_W+8){1'b0}};
         held_prev_reg <= 1'b0;
         met_reg <= 1'b0;
      end else if (!arm) begin
         hold_reg <= {(MIN_W+8){1'b0}};
         held_prev_reg <= 1'b0;
         met_reg <= 1'b0;
      end else begin
         if (!rel_true)
            hold_reg <= {(MIN_W+8){1'b0}};
         else if (hold_reg != {(MIN_W+8){1'b1}})
            hold_reg <= hold_reg + 1'b1;
         if (sample_stb) begin
            held_prev_reg <= held;
            // Edge mode fires only on the false-to-true sample
            met_reg <= edge_en ? (held && !held_prev_reg) : held;
         end else if (edge_en)
            met_reg <= 1'b0;
      end
   end
endmodule // stu_cond
`default_nettype wire

// ---- logic/stu_top.v ----
// Trigger unit top: APB registers, mode logic, trigger pulse generation.
// Assumes one pclk domain; sample sources synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
`include "stu_map.vh"
// Function
// - Stop-forced mode triggers on stop, ignoring pre-trigger fill.
// - Start mode triggers after start once pre-trigger fill completes.
// - Simple mode triggers when condition one is met and pre-trigger done.
// - Logic mode triggers when operator result true and pre-trigger done.
// - Simple mode uses one condition, logic mode two independent conditions.
// - A condition is source, relational test and comparison value.
// - Source is inactive, parameter, signal, or typed memory address.
// - Stop-forced mode makes sources inactive, so no comparison counts.
// - Relations: lt, le, gt, ge, eq, ne, source left of value.
// - Condition met only after test held true for minimum microseconds.
// - Absolute option compares magnitudes of source and value.
// - Mask option tests only the selected source bit.
// - Edge detection is enabled per condition independently.
// - Operators AND OR XOR NAND NOR XNOR first-only second-only.
// - Not trigger-ready until pre-trigger percentage of memory filled.
module stu_top #(
   parameter DEPTH_W = 16,
   parameter MIN_W = 16
) (
   // APB
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Sample sources
   input wire sample_stb,
   input wire [31:0] param0_val,
   input wire [31:0] signal0_val,
   input wire [31:0] addr0_val,
   input wire [31:0] param1_val,
   input wire [31:0] signal1_val,
   input wire [31:0] addr1_val,
   // Capture memory side
   input wire [DEPTH_W-1:0] capture_depth,
   output reg trigger_pulse,
   output reg recording
);
   localparam ST_IDLE = 2'h0;
   localparam ST_ARMED = 2'h1;
   localparam ST_DONE = 2'h2;

   reg [31:0] ctrl_reg;
   reg [7:0] pre_reg;
   reg [31:0] c0_cfg_reg;
   reg [31:0] c0_cmp_reg;
   reg [MIN_W-1:0] c0_min_reg;
   reg [31:0] c1_cfg_reg;
   reg [31:0] c1_cmp_reg;
   reg [MIN_W-1:0] c1_min_reg;
   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg start_cmd_reg;
   reg stop_cmd_reg;
   reg fire_next;
   reg logic_res;
   reg [31:0] rd_next;
   reg hit;
   wire [1:0] mode = ctrl_reg[`STU_CTRL_MODE_LSB+1:`STU_CTRL_MODE_LSB];
   wire [2:0] op = ctrl_reg[`STU_CTRL_OP_LSB+2:`STU_CTRL_OP_LSB];
   wire setup = psel && !penable;
   // Writes land in the access phase, at the edge where the master sees pready
   wire wr = psel && penable && pready && pwrite;
   wire pre_ready;
   wire met0;
   wire met1;
   wire armed = (state_reg == ST_ARMED);
   wire [31:0] c0_cfg_eff;
   wire [31:0] c1_cfg_eff;

   // Stop-forced mode overrides both sources to inactive
   assign c0_cfg_eff = (mode == `STU_MODE_STOP) ?
      {c0_cfg_reg[31:2], `STU_SRC_INACTIVE} : c0_cfg_reg;
   assign c1_cfg_eff = (mode == `STU_MODE_LOGIC) ?
      c1_cfg_reg : {c1_cfg_reg[31:2], `STU_SRC_INACTIVE};

   // Register writes; start and stop are self-clearing command bits
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= `STU_CTRL_RST;
         pre_reg <= 8'h00;
         c0_cfg_reg <= `STU_CFG_RST;
         c0_cmp_reg <= 32'h00000000;
         c0_min_reg <= {MIN_W{1'b0}};
         c1_cfg_reg <= `STU_CFG_RST;
         c1_cmp_reg <= 32'h00000000;
         c1_min_reg <= {MIN_W{1'b0}};
         start_cmd_reg <= 1'b0;
         stop_cmd_reg <= 1'b0;
      end else begin
         start_cmd_reg <= 1'b0;
         stop_cmd_reg <= 1'b0;
         if (wr) begin
            if (paddr == `STU_CTRL_OFF) begin
               ctrl_reg <= {25'h0000000, pwdata[6:0]};
               start_cmd_reg <= pwdata[`STU_CTRL_START_BIT];
               stop_cmd_reg <= pwdata[`STU_CTRL_STOP_BIT];
            end else if (paddr == `STU_PRE_OFF)
               // Percentages above full are clamped to full
               pre_reg <= (pwdata[7:0] > `STU_PRE_MAX) ? `STU_PRE_MAX : pwdata[7:0];
            else if (paddr == `STU_C0_CFG_OFF)
               c0_cfg_reg <= pwdata & 32'h001f07ff;
            else if (paddr == `STU_C0_CMP_OFF)
               c0_cmp_reg <= pwdata;
            else if (paddr == `STU_C0_MIN_OFF)
               c0_min_reg <= pwdata[MIN_W-1:0];
            else if (paddr == `STU_C1_CFG_OFF)
               c1_cfg_reg <= pwdata & 32'h001f07ff;
            else if (paddr == `STU_C1_CMP_OFF)
               c1_cmp_reg <= pwdata;
            else if (paddr == `STU_C1_MIN_OFF)
               c1_min_reg <= pwdata[MIN_W-1:0];
         end
      end
   end

   // Read decode; unmapped addresses answer with pslverr
   always @* begin
      rd_next = 32'h00000000;
      hit = 1'b1;
      if (paddr == `STU_CTRL_OFF)
         rd_next = ctrl_reg;
      else if (paddr == `STU_STAT_OFF)
         rd_next = {28'h0000000, pre_ready, state_reg, recording};
      else if (paddr == `STU_PRE_OFF)
         rd_next = {24'h000000, pre_reg};
      else if (paddr == `STU_C0_CFG_OFF)
         rd_next = c0_cfg_reg;
      else if (paddr == `STU_C0_CMP_OFF)
         rd_next = c0_cmp_reg;
      else if (paddr == `STU_C0_MIN_OFF)
         rd_next = {{(32-MIN_W){1'b0}}, c0_min_reg};
      else if (paddr == `STU_C1_CFG_OFF)
         rd_next = c1_cfg_reg;
      else if (paddr == `STU_C1_CMP_OFF)
         rd_next = c1_cmp_reg;
      else if (paddr == `STU_C1_MIN_OFF)
         rd_next = {{(32-MIN_W){1'b0}}, c1_min_reg};
      else if (paddr == `STU_SRC0_OFF)
         rd_next = {31'h00000000, met0};
      else if (paddr == `STU_SRC1_OFF)
         rd_next = {31'h00000000, met1};
      else
         hit = 1'b0;
   end

   // APB answer: one wait-free access phase, registered outputs
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         pslverr <= setup && !hit;
         prdata <= (setup && !pwrite) ? rd_next : 32'h00000000;
      end
   end

   // Operator over both conditions
   always @* begin
      case (op)
         `STU_OP_AND: logic_res = met0 & met1;
         `STU_OP_OR: logic_res = met0 | met1;
         `STU_OP_XOR: logic_res = met0 ^ met1;
         `STU_OP_NAND: logic_res = ~(met0 & met1);
         `STU_OP_NOR: logic_res = ~(met0 | met1);
         `STU_OP_XNOR: logic_res = ~(met0 ^ met1);
         `STU_OP_FIRST: logic_res = met0;
         default: logic_res = met1;
      endcase
   end

   // Recording sequencer; a new start always re-arms, even mid-recording
   always @* begin
      state_next = state_reg;
      fire_next = 1'b0;
      case (state_reg)
         ST_ARMED: begin
            if (mode == `STU_MODE_STOP)
               fire_next = stop_cmd_reg;
            else if (mode == `STU_MODE_START)
               fire_next = pre_ready;
            else if (mode == `STU_MODE_SIMPLE)
               fire_next = pre_ready && met0;
            else
               fire_next = pre_ready && logic_res;
            if (fire_next)
               state_next = ST_DONE;
            else if (stop_cmd_reg)
               state_next = ST_IDLE;
         end
         ST_DONE: state_next = ST_DONE;
         default: state_next = ST_IDLE;
      endcase
      if (start_cmd_reg) begin
         state_next = ST_ARMED;
         fire_next = 1'b0;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_IDLE;
         trigger_pulse <= 1'b0;
         recording <= 1'b0;
      end else begin
         state_reg <= state_next;
         trigger_pulse <= fire_next;
         recording <= (state_next == ST_ARMED);
      end
   end

   stu_pretrig #(
      .DEPTH_W(DEPTH_W)
   ) u_pre (
      .pclk(pclk),
      .presetn(presetn),
      .start(start_cmd_reg),
      .sample_stb(sample_stb),
      .pre_pct(pre_reg),
      .depth(capture_depth),
      .ready_reg(pre_ready)
   );

   stu_cond #(
      .MIN_W(MIN_W)
   ) u_c0 (
      .pclk(pclk),
      .presetn(presetn),
      .sample_stb(sample_stb),
      .param_val(param0_val),
      .signal_val(signal0_val),
      .addr_val(addr0_val),
      .cfg(c0_cfg_eff),
      .cmp_val(c0_cmp_reg),
      .min_us(c0_min_reg),
      .arm(armed),
      .met_reg(met0)
   );

   stu_cond #(
      .MIN_W(MIN_W)
   ) u_c1 (
      .pclk(pclk),
      .presetn(presetn),
      .sample_stb(sample_stb),
      .param_val(param1_val),
      .signal_val(signal1_val),
      .addr_val(addr1_val),
      .cfg(c1_cfg_eff),
      .cmp_val(c1_cmp_reg),
      .min_us(c1_min_reg),
      .arm(armed),
      .met_reg(met1)
   );
endmodule // stu_top
`default_nettype wire

// ---- tb/stu_props.sv ----
// Port-level checks for the trigger unit, bound onto stu_top.
// Assumes the offsets of stu_map.vh and a zero-wait APB slave.
`timescale 1ns/1ps
`default_nettype none
`include "stu_map.vh"
module stu_props (
   // APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Capture memory side
   input wire logic trigger_pulse,
   input wire logic recording
);
   logic [1:0] mode_q;
   wire logic setup = psel && !penable;
   wire logic ctrl_wr = setup && pwrite && paddr == `STU_CTRL_OFF;
   wire logic mapped = paddr inside {`STU_CTRL_OFF, `STU_STAT_OFF, `STU_PRE_OFF,
      `STU_C0_CFG_OFF, `STU_C0_CMP_OFF, `STU_C0_MIN_OFF, `STU_C1_CFG_OFF,
      `STU_C1_CMP_OFF, `STU_C1_MIN_OFF, `STU_SRC0_OFF, `STU_SRC1_OFF};

   // Mode in force, so a stop is judged against the mode it meets
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         mode_q <= `STU_MODE_STOP;
      else if (ctrl_wr)
         mode_q <= pwdata[1:0];
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Bus answer timing and contents
   ans_next_a: assert property (setup |=> pready)
      else $error("no answer after setup");
   ready_once_a: assert property (pready |=> !pready)
      else $error("ready held too long");
   err_map_a: assert property (pready |-> pslverr == !mapped)
      else $error("error flag disagrees with address");
   idle_data_a: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside answer");
   // Trigger pulse shape and arming
   trig_single_a: assert property (trigger_pulse |=> !trigger_pulse)
      else $error("trigger wider than one cycle");
   trig_ends_a: assert property (trigger_pulse |-> !recording && $past(recording))
      else $error("trigger outside a recording");
   stop_fire_a: assert property (ctrl_wr && pwdata[9] && !pwdata[8] && recording &&
      mode_q == `STU_MODE_STOP && pwdata[1:0] == `STU_MODE_STOP |-> ##[1:3] trigger_pulse)
      else $error("stop did not trigger");
   start_arm_a: assert property (ctrl_wr && pwdata[8] && !pwdata[9] |-> ##[1:3] recording)
      else $error("start did not arm");

   cover property (trigger_pulse);
   cover property (pready && pslverr);
   cover property (ctrl_wr && pwdata[9] && recording);
endmodule // stu_props

bind stu_top stu_props u_stu_props (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .trigger_pulse(trigger_pulse), .recording(recording));
`default_nettype wire

// ---- tb/stu_src_model.sv ----
// Stand-in for the drive's sampling path: sample strobes and source values.
// Assumes the bench sets the raw values and the gap between samples.
`timescale 1ns/1ps
`default_nettype none
module stu_src_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Bench settings
   input wire logic [3:0] gap,
   input wire logic [31:0] raw0,
   input wire logic [31:0] raw1,
   // Sampled values toward the unit
   output logic sample_stb,
   output logic [31:0] param0_val,
   output logic [31:0] signal0_val,
   output logic [31:0] addr0_val,
   output logic [31:0] param1_val,
   output logic [31:0] signal1_val,
   output logic [31:0] addr1_val
);
   logic [3:0] cnt_reg;

   // Strobe pacing; a large gap mimics a slow sampling time
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= 4'h0;
         sample_stb <= 1'b0;
      end else begin
         sample_stb <= cnt_reg == gap;
         cnt_reg <= (cnt_reg == gap) ? 4'h0 : cnt_reg + 4'h1;
      end
   end

   // Values move only with a sample; the three sources differ so selection shows
   always_ff @(posedge pclk) begin
      if (cnt_reg == gap) begin
         param0_val <= raw0;
         signal0_val <= ~raw0;
         addr0_val <= {raw0[15:0], raw0[31:16]};
         param1_val <= raw1;
         signal1_val <= ~raw1;
         addr1_val <= {raw1[15:0], raw1[31:16]};
      end
   end
endmodule // stu_src_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the trigger unit with a sampling-path model.
// Assumes stu_top, stu_src_model and the bound checker are compiled.
`timescale 1ns/1ps
`default_nettype none
`include "stu_map.vh"
module tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] raw0 = 32'h0;
   logic [31:0] raw1 = 32'h0;
   logic [3:0] gap = 4'h0;
   logic [15:0] depth = 16'h0014;
   logic [31:0] prdata, p0, s0, a0, p1, s1, a1, rd;
   logic pready, pslverr, sample_stb, trigger_pulse, recording, err_q, fired;
   int err_total = 0;
   int n_compared = 0;
   int cyc;

   // 125 MHz clock
   always #4 pclk = ~pclk;

   stu_top #(.DEPTH_W(16), .MIN_W(16)) u_stu_top (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample_stb(sample_stb),
      .param0_val(p0), .signal0_val(s0), .addr0_val(a0), .param1_val(p1),
      .signal1_val(s1), .addr1_val(a1), .capture_depth(depth),
      .trigger_pulse(trigger_pulse), .recording(recording));
   stu_src_model u_stu_src_model (.pclk(pclk), .presetn(presetn), .gap(gap), .raw0(raw0),
      .raw1(raw1), .sample_stb(sample_stb), .param0_val(p0), .signal0_val(s0),
      .addr0_val(a0), .param1_val(p1), .signal1_val(s1), .addr1_val(a1));

   // Count a comparison and report a difference at once
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   // One APB transfer; data and error taken at the ready edge only
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 16; n++) begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      chk(n < 16, 1'b1, "apb answer");
      rd = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Look for a trigger within maxc cycles, sampled mid-cycle
   task automatic watch(input int maxc);
      fired = 1'b0;
      for (cyc = 0; cyc < maxc && !fired; cyc++) begin
         @(negedge pclk);
         fired = trigger_pulse;
      end
   endtask

   // Idle the unit first so no hold count carries over; the start write clears the fill
   task automatic run(input logic [31:0] ctrl, c0, m0, c1, r0, r1, input int maxc);
      apb(1'b1, `STU_CTRL_OFF, ctrl | 32'h200);
      raw0 <= r0;
      raw1 <= r1;
      apb(1'b1, `STU_C0_CFG_OFF, c0);
      apb(1'b1, `STU_C0_CMP_OFF, m0);
      apb(1'b1, `STU_C1_CFG_OFF, c1);
      apb(1'b1, `STU_CTRL_OFF, ctrl | 32'h100);
      watch(maxc);
   endtask

   function automatic logic rel_ok(input int r, input int a, input int b);
      case (r)
         0: return a < b;
         1: return a <= b;
         2: return a > b;
         3: return a >= b;
         4: return a == b;
         default: return a != b;
      endcase
   endfunction

   function automatic logic op_ok(input int op, input logic x, input logic y);
      case (op)
         0: return x & y;
         1: return x | y;
         2: return x ^ y;
         3: return !(x & y);
         4: return !(x | y);
         5: return x ~^ y;
         6: return x;
         default: return y;
      endcase
   endfunction

   task automatic t_regs();
      apb(1'b0, `STU_CTRL_OFF, 32'h0);
      chk(rd, 32'h0, "ctrl reset");
      apb(1'b1, `STU_PRE_OFF, 32'hc8);
      apb(1'b0, `STU_PRE_OFF, 32'h0);
      chk(rd, 32'h64, "pre clamp");
      apb(1'b0, 12'h0fc, 32'h0);
      chk(err_q, 1'b1, "unmapped error");
      $display("t_regs done");
   endtask

   // Pre-trigger 100 percent of a deep memory: only the stop may fire
   task automatic t_stop();
      depth <= 16'hffff;
      run(32'h0, 32'h21, 32'h0, 32'h21, 32'h5, 32'h5, 40);
      chk(fired, 1'b0, "forced inactive");
      chk(recording, 1'b1, "recording while armed");
      apb(1'b0, `STU_SRC0_OFF, 32'h0);
      chk(rd, 32'h0, "forced inactive met");
      apb(1'b1, `STU_CTRL_OFF, 32'h200);
      watch(8);
      chk(fired, 1'b1, "stop trigger");
      chk(recording, 1'b0, "recording after stop");
      $display("t_stop done");
   endtask

   // Slow samples: half of 20 must be filled before the trigger
   task automatic t_start();
      apb(1'b1, `STU_PRE_OFF, 32'h32);
      depth <= 16'h0014;
      gap <= 4'h3;
      run(32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 300);
      chk(fired, 1'b1, "start trigger");
      chk(cyc >= 32, 1'b1, "fill wait");
      watch(100);
      chk(fired, 1'b0, "second trigger");
      apb(1'b1, `STU_PRE_OFF, 32'h0);
      gap <= 4'h0;
      run(32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 20);
      chk(fired && cyc <= 8, 1'b1, "no fill wait");
      $display("t_start done");
   endtask

   // Relations around the boundary; condition two is true but must not count
   task automatic t_simple();
      for (int r = 0; r < 6; r++) begin
         for (int v = 4; v < 7; v++) begin
            run(32'h2, 32'h1 | (r << 4), 32'h5, 32'h21, v, 32'h1, 40);
            chk(fired, rel_ok(r, v, 5), "relation");
         end
      end
      run(32'h2, 32'h42, 32'hfffffffa, 32'h0, 32'h5, 32'h0, 40);
      chk(fired, 1'b1, "signal source");
      run(32'h2, 32'h43, 32'h00050000, 32'h0, 32'h5, 32'h0, 40);
      chk(fired, 1'b1, "address source");
      run(32'h2, 32'h0b, 32'h0, 32'h0, 32'hfffe0000, 32'h0, 40);
      chk(fired, 1'b1, "signed 16-bit address");
      run(32'h2, 32'h0f, 32'h0, 32'h0, 32'hfffe0000, 32'h0, 40);
      chk(fired, 1'b0, "unsigned 16-bit address");
      run(32'h2, 32'h07, 32'h0, 32'h0, 32'h00008000, 32'h0, 40);
      chk(fired, 1'b0, "unsigned 32-bit address");
      run(32'h2, 32'h50, 32'h0, 32'h0, 32'h5, 32'h0, 40);
      chk(fired, 1'b0, "inactive source");
      $display("t_simple done");
   endtask

   task automatic t_logic();
      for (int op = 0; op < 8; op++) begin
         for (int k = 0; k < 4; k++) begin
            run(32'h3 | (op << 4), 32'h21, 32'h0, 32'h21, k[0], k[1], 40);
            chk(fired, op_ok(op, k[0], k[1]), "operator");
         end
      end
      $display("t_logic done");
   endtask

   task automatic t_opts();
      run(32'h2, 32'h121, 32'hfffffffd, 32'h0, 32'hfffffffb, 32'h0, 40);
      chk(fired, 1'b1, "abs compare");
      run(32'h2, 32'h21, 32'hfffffffd, 32'h0, 32'hfffffffb, 32'h0, 40);
      chk(fired, 1'b0, "signed compare");
      run(32'h2, 32'h40241, 32'h1, 32'h0, 32'h10, 32'h0, 40);
      chk(fired, 1'b1, "mask bit set");
      run(32'h2, 32'h40241, 32'h1, 32'h0, 32'hef, 32'h0, 40);
      chk(fired, 1'b0, "mask bit clear");
      apb(1'b1, `STU_C0_MIN_OFF, 32'h1);
      run(32'h2, 32'h21, 32'h0, 32'h0, 32'h1, 32'h0, 400);
      chk(fired && cyc >= 120, 1'b1, "minimum hold");
      apb(1'b1, `STU_C0_MIN_OFF, 32'h0);
      // Edge on one, level on the other: a late level must not revive the edge
      run(32'h3, 32'h421, 32'h0, 32'h21, 32'h1, 32'h0, 40);
      @(posedge pclk);
      raw1 <= 32'h1;
      watch(40);
      chk(fired, 1'b0, "edge held true");
      @(posedge pclk);
      raw0 <= 32'h0;
      repeat (6) @(posedge pclk);
      raw0 <= 32'h1;
      watch(40);
      chk(fired, 1'b1, "edge with level");
      $display("t_opts done");
   endtask

   task automatic end_of_test();
      $display("Compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_stop();
      t_start();
      t_simple();
      t_logic();
      t_opts();
      end_of_test();
   end

   // Watchdog well beyond the few thousand cycles the tests need
   initial begin
      repeat (30000) @(posedge pclk);
      err_total++;
      $display("MISMATCH %0t: watchdog expired", $time);
      end_of_test();
   end
endmodule // tb_top
`default_nettype wire
